// ===== rtl/mpio_top.sv
// Multiport pin control: ports 0,2,5,6,7,12,13 with their options.
// Assumes software control arrives as same-clock ports; pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "mpio_map.svh"

// Summary of operation
// R1: Per-pin output latch and per-bit direction chosen by software.
// R2: Weak pull-up enabled on input pins when its bit is set.
// R3: Input buffer type bit picks normal or TTL threshold.
// R4: Small package port-0 low pins reset analog; large package resets input.
// R5: Port 2: digital in, digital out, analog in; analog output prohibited.
// R6: Software allocates port-2 digital pins from top, analog from bottom.
// R7: Analog port-2 pin converted only when channel select picks it.
// R8: Reset puts all eight port-2 pins in analog input mode.
// R9: Port-5 low pins and port-7 bit 4 open-drain when mode bit set.
// R10: Port-6 pins are always open-drain, never drive high.
// R11: Port-12 pins one to four input-only, no latch or direction.
// R12: Port-12 pin zero resets analog; others reset as inputs.
// R13: Port-13 bit 0 fixed output with latch; bit 7 fixed input.
// R14: Port-13 output pin drives low during and after reset.
// R15: Plain digital ports reset to input mode.
// R16: Software writes initial values to control bits without pins.
// R17: Direction one is input with buffer off; reset loads all ones.
// R18: Port read gives pin level for inputs, latch for outputs.
// R19: Analog converter input pins read zero in input mode.
// R20: Reset clears output latches to zero.
// R21: Digital pin inputs pass a two-stage synchroniser before reading.
module mpio_top
	import mpio_pkg::*;
#(
	parameter bit SMALL_PKG = 1'b0
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Port 0
	input  wire logic        p0_latch_we,
	input  wire logic        p0_dir_we,
	input  wire logic        p0_ana_we,
	input  wire logic [1:0]  p0_wdata,
	input  wire logic [1:0]  p0_weak_high_enable,
	input  wire logic [1:0]  p0_input_buffer_type,
	input  wire logic [1:0]  p0_drain_only_select,
	output logic      [1:0]  p0_rdata,
	input  wire logic [1:0]  p0_pin_in,
	output logic      [1:0]  p0_pin_out,
	output logic      [1:0]  p0_pin_oe_n,
	output logic      [1:0]  p0_pull_en,
	output logic      [1:0]  p0_ttl_en,
	// Port 2 with converter
	input  wire logic        p2_latch_we,
	input  wire logic        p2_dir_we,
	input  wire logic        p2_ana_we,
	input  wire logic [7:0]  p2_wdata,
	input  wire logic [2:0]  converter_channel_select,
	output logic      [7:0]  p2_rdata,
	input  wire logic [7:0]  p2_pin_in,
	output logic      [7:0]  p2_pin_out,
	output logic      [7:0]  p2_pin_oe_n,
	output logic      [7:0]  converter_input,
	output logic             p2_bad_setting,
	// Port 5
	input  wire logic        p5_latch_we,
	input  wire logic        p5_dir_we,
	input  wire logic [1:0]  p5_wdata,
	input  wire logic [1:0]  p5_weak_high_enable,
	input  wire logic        p5_input_buffer_type,
	input  wire logic [1:0]  p5_drain_only_select,
	output logic      [1:0]  p5_rdata,
	input  wire logic [1:0]  p5_pin_in,
	output logic      [1:0]  p5_pin_out,
	output logic      [1:0]  p5_pin_oe_n,
	output logic      [1:0]  p5_pull_en,
	output logic             p5_ttl_en,
	// Port 6
	input  wire logic        p6_latch_we,
	input  wire logic        p6_dir_we,
	input  wire logic [3:0]  p6_wdata,
	output logic      [3:0]  p6_rdata,
	input  wire logic [3:0]  p6_pin_in,
	output logic      [3:0]  p6_pin_out,
	output logic      [3:0]  p6_pin_oe_n,
	// Port 7
	input  wire logic        p7_latch_we,
	input  wire logic        p7_dir_we,
	input  wire logic [5:0]  p7_wdata,
	input  wire logic [5:0]  p7_weak_high_enable,
	input  wire logic        p7_drain_only_select,
	output logic      [5:0]  p7_rdata,
	input  wire logic [5:0]  p7_pin_in,
	output logic      [5:0]  p7_pin_out,
	output logic      [5:0]  p7_pin_oe_n,
	output logic      [5:0]  p7_pull_en,
	// Port 12 and port 13
	input  wire logic        p12_latch_we,
	input  wire logic        p12_dir_we,
	input  wire logic        p12_ana_we,
	input  wire logic        p12_wdata,
	input  wire logic        p12_weak_high_enable,
	output logic      [4:0]  p12_rdata,
	input  wire logic [4:0]  p12_pin_in,
	output logic             p12_pin_out,
	output logic             p12_pin_oe_n,
	output logic             p12_pull_en,
	input  wire logic        p13_latch_we,
	input  wire logic        p13_wdata,
	output logic      [7:0]  p13_rdata,
	input  wire logic        p137_pin_in,
	output logic             p130_pin_out
);
	localparam logic [7:0] P0_ANA = SMALL_PKG ? `MPIO_ANA_RST : 8'h00; // R4

	wire [1:0] p0_ana;
	wire [7:0] p2_dir;
	wire [7:0] p2_ana;
	wire [3:0] p12_hi_sync;
	wire       p137_sync;
	wire [7:0] chan_hit;
	wire       p12_rd0;
	logic [1:0] ttl0_ff;
	logic       ttl5_ff;
	logic [7:0] conv_ff;
	logic       bad_ff;
	logic       p130_ff;
	logic [7:0] p13_rd_ff;
	logic [3:0] p12_hi_ff;
	wire [7:0] p2_bad_bit;

	// Port 0; analog select writes are ignored on the large package
	mpio_port #(.W(2), .ANA_RST(P0_ANA)) u_p0 (
		.mclk(mclk),
		.rst_n(rst_n),
		.latch_we(p0_latch_we),
		.latch_wdata(p0_wdata),
		.dir_we(p0_dir_we),
		.dir_wdata(p0_wdata),
		.ana_we(p0_ana_we & SMALL_PKG), // R4
		.ana_wdata(p0_wdata),
		.weak_high_enable(p0_weak_high_enable),
		.drain_only_select(p0_drain_only_select),
		.port_rdata(p0_rdata),
		.direction_select(),
		.analog_mode(p0_ana),
		.pin_in(p0_pin_in),
		.pin_out(p0_pin_out),
		.pin_oe_n(p0_pin_oe_n),
		.pull_en(p0_pull_en)
	);

	// Port 2: converter pins, all analog after reset
	mpio_port #(.W(8), .ANA_RST(`MPIO_P2_ANA_RST)) u_p2 (
		.mclk(mclk),
		.rst_n(rst_n),
		.latch_we(p2_latch_we),
		.latch_wdata(p2_wdata),
		.dir_we(p2_dir_we),
		.dir_wdata(p2_wdata),
		.ana_we(p2_ana_we), // R8
		.ana_wdata(p2_wdata),
		.weak_high_enable(8'h00),
		.drain_only_select(8'h00),
		.port_rdata(p2_rdata),
		.direction_select(p2_dir),
		.analog_mode(p2_ana),
		.pin_in(p2_pin_in),
		.pin_out(p2_pin_out),
		.pin_oe_n(p2_pin_oe_n),
		.pull_en()
	);

	// Port 5: both pins may be switched to open-drain
	mpio_port #(.W(2)) u_p5 (
		.mclk(mclk),
		.rst_n(rst_n),
		.latch_we(p5_latch_we),
		.latch_wdata(p5_wdata),
		.dir_we(p5_dir_we), // R15
		.dir_wdata(p5_wdata),
		.ana_we(1'b0),
		.ana_wdata(2'h0),
		.weak_high_enable(p5_weak_high_enable),
		.drain_only_select(p5_drain_only_select), // R9
		.port_rdata(p5_rdata),
		.direction_select(),
		.analog_mode(),
		.pin_in(p5_pin_in),
		.pin_out(p5_pin_out),
		.pin_oe_n(p5_pin_oe_n),
		.pull_en(p5_pull_en)
	);

	// Port 6: open-drain only, no pull-up
	mpio_port #(.W(4)) u_p6 (
		.mclk(mclk),
		.rst_n(rst_n),
		.latch_we(p6_latch_we),
		.latch_wdata(p6_wdata),
		.dir_we(p6_dir_we),
		.dir_wdata(p6_wdata),
		.ana_we(1'b0),
		.ana_wdata(4'h0),
		.weak_high_enable(4'h0),
		.drain_only_select(4'hF), // R10
		.port_rdata(p6_rdata),
		.direction_select(),
		.analog_mode(),
		.pin_in(p6_pin_in),
		.pin_out(p6_pin_out),
		.pin_oe_n(p6_pin_oe_n),
		.pull_en()
	);

	// Port 7: open-drain option on bit 4 only
	mpio_port #(.W(6)) u_p7 (
		.mclk(mclk),
		.rst_n(rst_n),
		.latch_we(p7_latch_we),
		.latch_wdata(p7_wdata),
		.dir_we(p7_dir_we),
		.dir_wdata(p7_wdata),
		.ana_we(1'b0),
		.ana_wdata(6'h00),
		.weak_high_enable(p7_weak_high_enable),
		.drain_only_select({1'b0, p7_drain_only_select, 4'h0}), // R9
		.port_rdata(p7_rdata),
		.direction_select(),
		.analog_mode(),
		.pin_in(p7_pin_in),
		.pin_out(p7_pin_out),
		.pin_oe_n(p7_pin_oe_n),
		.pull_en(p7_pull_en)
	);

	// Port 12 bit 0: the only port-12 pin with latch and direction
	mpio_port #(.W(1), .ANA_RST({7'h00, `MPIO_P12_ANA_RST})) u_p12 (
		.mclk(mclk),
		.rst_n(rst_n),
		.latch_we(p12_latch_we),
		.latch_wdata(p12_wdata),
		.dir_we(p12_dir_we),
		.dir_wdata(p12_wdata),
		.ana_we(p12_ana_we), // R12
		.ana_wdata(p12_wdata),
		.weak_high_enable(p12_weak_high_enable),
		.drain_only_select(1'b0),
		.port_rdata(p12_rd0),
		.direction_select(),
		.analog_mode(),
		.pin_in(p12_pin_in[0]),
		.pin_out(p12_pin_out),
		.pin_oe_n(p12_pin_oe_n),
		.pull_en(p12_pull_en)
	);

	// Input-only pins of ports 12 and 13
	mpio_sync #(.W(5)) u_sync_in (
		.mclk(mclk),
		.rst_n(rst_n),
		.d_in({p137_pin_in, p12_pin_in[4:1]}),
		.q_out({p137_sync, p12_hi_sync})
	); // R21

	// Port 2 mode per bit; an analog output bit is flagged, never driven
	for (genvar b = 0; b < 8; b++) begin : g_p2_mode
		mpio_mode_e mode;
		assign mode = p2_ana[b] ? (p2_dir[b] ? MPIO_ANA_IN : MPIO_BAD)
		            : (p2_dir[b] ? MPIO_DIG_IN : MPIO_DIG_OUT); // R5
		assign p2_bad_bit[b] = (mode == MPIO_BAD); // R5
	end
	assign chan_hit = 8'h01 << converter_channel_select;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ttl0_ff   <= 2'h0;
			ttl5_ff   <= 1'h0;
			conv_ff   <= 8'h00;
			bad_ff    <= 1'h0;
			p130_ff   <= `MPIO_P130_RST; // R14
			p13_rd_ff <= 8'h00;
			p12_hi_ff <= 4'h0;
		end else begin
			ttl0_ff   <= p0_input_buffer_type & ~p0_ana; // R3
			ttl5_ff   <= p5_input_buffer_type; // R3
			conv_ff   <= chan_hit & p2_ana & p2_dir; // R7
			bad_ff    <= |p2_bad_bit; // R5
			if (p13_latch_we) p130_ff <= p13_wdata; // R13
			p13_rd_ff <= {p137_sync, 6'h00, p130_ff}; // R13
			p12_hi_ff <= p12_hi_sync; // R11
		end
	end

	assign p0_ttl_en       = ttl0_ff;
	assign p5_ttl_en       = ttl5_ff;
	assign converter_input = conv_ff;
	assign p2_bad_setting  = bad_ff;
	assign p130_pin_out    = p130_ff;
	assign p13_rdata       = p13_rd_ff;
	assign p12_rdata       = {p12_hi_ff, p12_rd0};
endmodule : mpio_top

`default_nettype wire

// ===== common/mpio_map.svh
// Constants for the multiport pin control block: reset values and counts.
// Assumes inclusion by bare name from rtl files and the package.
`ifndef MPIO_MAP_SVH
`define MPIO_MAP_SVH

`define MPIO_DIR_RST      8'hFF
`define MPIO_LATCH_RST    8'h00
`define MPIO_CTRL_RST     8'h00
`define MPIO_ANA_RST      8'hFF
`define MPIO_P2_ANA_RST   8'hFF
`define MPIO_P12_ANA_RST  1'h1
`define MPIO_P130_RST     1'h0
`define MPIO_SYNC_STAGES  2
`define MPIO_P0_WIDTH     2
`define MPIO_P2_WIDTH     8
`define MPIO_P5_WIDTH     2
`define MPIO_P6_WIDTH     4
`define MPIO_P7_WIDTH     6
`define MPIO_P12_IN_WIDTH 4

`endif

// ===== common/mpio_pkg.sv
// Types for the multiport pin control block.
// Assumes the map header sits beside it on the include path.
`include "mpio_map.svh"

package mpio_pkg;
	typedef enum logic [1:0] {
		MPIO_DIG_IN,
		MPIO_DIG_OUT,
		MPIO_ANA_IN,
		MPIO_BAD
	} mpio_mode_e;
	typedef logic [7:0] mpio_byte_t;
endpackage : mpio_pkg

// ===== rtl/mpio_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes pin inputs are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module mpio_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule : mpio_sync

`default_nettype wire

// ===== rtl/mpio_port.sv
// One general purpose port of up to eight bits: latch, direction, pull-up,
// optional open-drain, read-back and analog gating.
// Assumes control bits come from same-clock software logic, pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "mpio_map.svh"

module mpio_port
	import mpio_pkg::*;
#(
	parameter int         W       = 8,
	parameter logic [7:0] ANA_RST = 8'h00
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// Software write side
	input  wire logic         latch_we,
	input  wire logic [W-1:0] latch_wdata,
	input  wire logic         dir_we,
	input  wire logic [W-1:0] dir_wdata,
	input  wire logic         ana_we,
	input  wire logic [W-1:0] ana_wdata,
	// Static per-bit controls
	input  wire logic [W-1:0] weak_high_enable,
	input  wire logic [W-1:0] drain_only_select,
	// Read side
	output logic      [W-1:0] port_rdata,
	output logic      [W-1:0] direction_select,
	output logic      [W-1:0] analog_mode,
	// Pin side
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out,
	output logic      [W-1:0] pin_oe_n,
	output logic      [W-1:0] pull_en
);
	logic [W-1:0] latch_ff;
	logic [W-1:0] dir_ff;
	logic [W-1:0] ana_ff;
	logic [W-1:0] pin_sync;
	logic [W-1:0] rd_ff;
	logic [W-1:0] oe_n_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] pull_ff;
	wire  [W-1:0] nxt_rd;
	wire  [W-1:0] nxt_oe_n;
	wire  [W-1:0] nxt_out;
	wire  [W-1:0] drive_on;

	mpio_sync #(.W(W)) u_sync (
		.mclk (mclk),
		.rst_n(rst_n),
		.d_in (pin_in),
		.q_out(pin_sync)
	); // R21

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			latch_ff <= W'(`MPIO_LATCH_RST); // R20
			dir_ff   <= W'(`MPIO_DIR_RST); // R17
			ana_ff   <= ANA_RST[W-1:0];
		end else begin
			if (latch_we) latch_ff <= latch_wdata; // R1
			if (dir_we) dir_ff <= dir_wdata; // R1
			if (ana_we) ana_ff <= ana_wdata;
		end
	end

	// Output only when digital and direction zero; analog output is refused
	assign drive_on = ~dir_ff & ~ana_ff; // R5 R17
	// Open-drain pins release instead of driving a one
	assign nxt_oe_n = ~(drive_on & ~(drain_only_select & latch_ff)); // R9 R10
	assign nxt_out  = latch_ff & ~drain_only_select; // R10
	// Input bits show the pin, analog input bits read zero, outputs show latch
	assign nxt_rd   = (dir_ff & ~ana_ff & pin_sync)
	                | (~dir_ff & latch_ff); // R18 R19

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_ff   <= '0;
			oe_n_ff <= '1;
			out_ff  <= '0;
			pull_ff <= '0;
		end else begin
			rd_ff   <= nxt_rd;
			oe_n_ff <= nxt_oe_n;
			out_ff  <= nxt_out;
			pull_ff <= weak_high_enable & dir_ff & ~ana_ff; // R2
		end
	end

	assign port_rdata       = rd_ff;
	assign pin_oe_n         = oe_n_ff;
	assign pin_out          = out_ff;
	assign pull_en          = pull_ff;
	assign direction_select = dir_ff;
	assign analog_mode      = ana_ff;
endmodule : mpio_port

`default_nettype wire

// ===== dv/mpio_board.sv
// Board-side model of the pins: device drive, pull-up, external driver.
// Assumes the bench steers the external driver at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mpio_board #(
	parameter int W = 8
) (
	// Clock
	input  wire logic         mclk,
	// Device side
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	input  wire logic [W-1:0] pull_en,
	// External driver
	input  wire logic [W-1:0] drive_en,
	input  wire logic [W-1:0] drive_val,
	// Level seen by the device
	output logic      [W-1:0] pin_in
);
	logic [W-1:0] float_ff = '0;
	// A floating line without pull-up wanders every cycle
	always @(posedge mclk) float_ff <= ~float_ff;
	assign pin_in = ~pin_oe_n & pin_out
		| pin_oe_n & drive_en & drive_val
		| pin_oe_n & ~drive_en & (pull_en | float_ff);
endmodule : mpio_board
`default_nettype wire

// ===== dv/mpio_props.sv
// Checker for the multiport pin block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mpio_props (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst_n,
	// Port 2, 5 and 6
	input wire logic [2:0] converter_channel_select,
	input wire logic [7:0] converter_input,
	input wire logic [7:0] p2_pin_oe_n,
	input wire logic [7:0] p2_rdata,
	input wire logic [1:0] p5_drain_only_select,
	input wire logic [1:0] p5_pin_out,
	input wire logic [1:0] p5_pin_oe_n,
	input wire logic [3:0] p6_pin_out,
	input wire logic [3:0] p6_pin_oe_n,
	// Port 7
	input wire logic       p7_latch_we,
	input wire logic       p7_drain_only_select,
	input wire logic [5:0] p7_wdata,
	input wire logic [5:0] p7_pin_in,
	input wire logic [5:0] p7_rdata,
	input wire logic [5:0] p7_pin_out,
	input wire logic [5:0] p7_pin_oe_n,
	input wire logic [5:0] p7_pull_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_p7_wr;
		p7_latch_we ##1 !p7_latch_we;
	endsequence
	sequence s_p7_idle;
		(p7_pin_oe_n == 6'h3F && !p7_drain_only_select
			&& $stable(p7_pin_in)) [*4];
	endsequence
	property p_p7_latch;
		s_p7_wr |=> p7_pin_out[3:0] == $past(p7_wdata[3:0], 2);
	endproperty
	a_p7_latch: assert property (p_p7_latch)
		else $error("p7 drive differs from written latch");
	property p_p7_sync;
		s_p7_idle |-> p7_rdata == p7_pin_in;
	endproperty
	a_p7_sync: assert property (p_p7_sync)
		else $error("p7 read differs from settled pins");
	property p_p6_od;
		(p6_pin_out & ~p6_pin_oe_n) == 4'h0;
	endproperty
	a_p6_od: assert property (p_p6_od)
		else $error("p6 drove high");
	property p_p5_od;
		p5_drain_only_select[0] [*2] |-> !(p5_pin_out[0] && !p5_pin_oe_n[0]);
	endproperty
	a_p5_od: assert property (p_p5_od)
		else $error("p5 open drain drove high");
	property p_sel;
		converter_input == 8'h00
			|| converter_input == 8'h01 << $past(converter_channel_select);
	endproperty
	a_sel: assert property (p_sel)
		else $error("converter input not the selected channel");
	property p_ana_out;
		(converter_input & ~p2_pin_oe_n) == 8'h00;
	endproperty
	a_ana_out: assert property (p_ana_out)
		else $error("analog pin driven");
	property p_ana_rd;
		(converter_input & p2_rdata) == 8'h00;
	endproperty
	a_ana_rd: assert property (p_ana_rd)
		else $error("analog pin read nonzero");
	property p_pull;
		(p7_pull_en & ~p7_pin_oe_n) == 6'h00;
	endproperty
	a_pull: assert property (p_pull)
		else $error("pull-up on a driven pin");
endmodule : mpio_props
bind mpio_top mpio_props mpio_props_i (.*);
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the multiport pin block.
// Assumes the board model; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 0, rst_n = 0, p0_latch_we = 0, p0_dir_we = 0, p0_ana_we = 0;
	logic p2_latch_we = 0, p2_dir_we = 0, p2_ana_we = 0, p5_latch_we = 0;
	logic p5_dir_we = 0, p5_input_buffer_type = 0, p6_latch_we = 0;
	logic p6_dir_we = 0, p7_latch_we = 0, p7_dir_we = 0, p12_latch_we = 0;
	logic p7_drain_only_select = 0, p12_dir_we = 0, p12_ana_we = 0;
	logic p12_wdata = 0, p12_weak_high_enable = 0, p13_latch_we = 0;
	logic p13_wdata = 0, p137_pin_in = 0, p2_bad_setting, p5_ttl_en;
	logic p12_pin_out, p12_pin_oe_n, p12_pull_en, p130_pin_out;
	logic [1:0] p0_wdata = 0, p0_weak_high_enable = 0, p0_pin_in = 0;
	logic [1:0] p0_input_buffer_type = 0, p0_drain_only_select = 0;
	logic [1:0] p5_wdata = 0, p5_weak_high_enable = 0, p5_pin_in = 0;
	logic [1:0] p5_drain_only_select = 0, p0_rdata, p0_pin_out, p0_pin_oe_n;
	logic [1:0] p0_pull_en, p0_ttl_en, p5_rdata, p5_pin_out, p5_pin_oe_n;
	logic [1:0] p5_pull_en;
	logic [2:0] converter_channel_select = 0;
	logic [3:0] p6_wdata = 0, p6_rdata, p6_pin_in, p6_pin_out, p6_pin_oe_n;
	logic [4:0] p12_rdata, p12_pin_in = 0;
	logic [5:0] p7_wdata = 0, p7_weak_high_enable = 0, p7_rdata, p7_pin_in;
	logic [5:0] p7_pin_out, p7_pin_oe_n, p7_pull_en;
	logic [7:0] p2_wdata = 0, p2_rdata, p2_pin_in, p2_pin_out, p2_pin_oe_n;
	logic [7:0] converter_input, p13_rdata, den = 8'hFF, dval = 8'h00;
	logic [31:0] seed = 32'h6BBEC855;
	int errors = 0, num_checks = 0, lat, dir, ana, od, wh, ch;
	assign p2_pin_in = dval;
	assign p6_pin_in = dval[3:0];
	mpio_top mpio_top_i (.*);
	mpio_board #(.W(6)) board7 (
		.mclk,
		.pin_out  (p7_pin_out),
		.pin_oe_n (p7_pin_oe_n),
		.pull_en  (p7_pull_en),
		.drive_en (den[5:0]),
		.drive_val(dval[5:0]),
		.pin_in   (p7_pin_in)
	);
	initial begin
		forever #10 mclk = ~mclk;
	end
	initial begin
		#100000;
		errors++;
		end_sim();
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Same data to every port; k selects latch, direction, analog strobes
	task automatic wr(input logic [31:0] v, input logic [2:0] k);
		p0_wdata = v[1:0];
		p2_wdata = v[7:0];
		p5_wdata = v[1:0];
		p6_wdata = v[3:0];
		p7_wdata = v[5:0];
		p12_wdata = v[0];
		p13_wdata = v[0];
		{p0_latch_we, p2_latch_we, p5_latch_we, p6_latch_we} = {4{k[0]}};
		{p7_latch_we, p12_latch_we, p13_latch_we} = {3{k[0]}};
		{p0_dir_we, p2_dir_we, p5_dir_we, p6_dir_we} = {4{k[1]}};
		{p7_dir_we, p12_dir_we} = {2{k[1]}};
		{p0_ana_we, p2_ana_we, p12_ana_we} = {3{k[2]}};
	endtask : wr
	task automatic port(input int w, an, odm, whm, dn,
		input logic [7:0] rd, oe, po, pu);
		int m, eoe, epu, msk, pv;
		m = (1 << w) - 1;
		eoe = (dir | an | odm & lat) & m;
		epu = whm & dir & ~an & m;
		pv = dn & dval | ~dn & epu;
		msk = (~dir | dn | epu | an) & m;
		chk(rd & msk, (dir & ~an & pv | ~dir & lat) & msk);
		chk(oe, eoe);
		chk(po & ~eoe & m, lat & ~eoe & m);
		chk(pu, epu);
	endtask : port
	task automatic check_all();
		port(2, 0, od & 3, wh, 255, p0_rdata, p0_pin_oe_n, p0_pin_out,
			p0_pull_en);
		port(2, 0, od & 3, wh, 255, p5_rdata, p5_pin_oe_n, p5_pin_out,
			p5_pull_en);
		port(6, 0, od & 16, wh, den, p7_rdata, p7_pin_oe_n, p7_pin_out,
			p7_pull_en);
		port(4, 0, 15, 0, 255, p6_rdata, p6_pin_oe_n, p6_pin_out, 0);
		port(8, ana, 0, 0, 255, p2_rdata, p2_pin_oe_n, p2_pin_out, 0);
		port(1, ana & 1, 0, wh, 255, p12_rdata, p12_pin_oe_n, p12_pin_out,
			p12_pull_en);
		chk(p12_rdata[4:1], dval[4:1]);
		chk(p13_rdata, {dval[7], 6'h00, lat[0]});
		chk(p2_bad_setting, |(ana & ~dir & 255));
		chk(converter_input, ana & dir & (1 << ch) & 255);
		chk(p0_ttl_en, od[3:2]);
		chk(p5_ttl_en, od[5]);
	endtask : check_all
	task automatic after_reset();
		lat = 0;
		dir = 255;
		ana = 255;
		repeat (6) @(negedge mclk);
		check_all();
	endtask : after_reset
	initial begin
		repeat (2) @(negedge mclk);
		rst_n = 1;
		od = 0;
		wh = 0;
		ch = 0;
		after_reset();
		$display("reset values done");
		for (int i = 0; i < 60; i++) begin
			lat = rnd();
			dir = rnd();
			ana = (1 << (rnd() % 9)) - 1;
			od = rnd();
			wh = rnd();
			ch = rnd() & 7;
			dval = rnd();
			den = (i % 3 == 0) ? 8'hFF : rnd();
			if (i == 59)
				lat = lat | 1;
			@(negedge mclk);
			converter_channel_select = ch[2:0];
			p0_weak_high_enable = wh[1:0];
			p5_weak_high_enable = wh[1:0];
			p7_weak_high_enable = wh[5:0];
			p12_weak_high_enable = wh[0];
			p0_drain_only_select = od[1:0];
			p5_drain_only_select = od[1:0];
			p7_drain_only_select = od[4];
			p0_input_buffer_type = od[3:2];
			p5_input_buffer_type = od[5];
			p0_pin_in = dval[1:0];
			p5_pin_in = dval[1:0];
			p12_pin_in = dval[4:0];
			p137_pin_in = dval[7];
			wr(lat, 3'h1);
			@(negedge mclk);
			wr(dir, 3'h2);
			@(negedge mclk);
			wr(ana, 3'h4);
			@(negedge mclk);
			wr(0, 3'h0);
			repeat (6) @(negedge mclk);
			check_all();
		end
		$display("random traffic done");
		rst_n = 0;
		@(negedge mclk);
		chk(p130_pin_out, 0);
		@(negedge mclk);
		rst_n = 1;
		after_reset();
		$display("mid-run reset done");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
